/* File: design/scr_regs.sv */
// system control register bank with external interrupt flags and wake logic
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module scr_regs (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire scr_pkg::scr_apb_req_t       apb_req,
    output logic                             pready,
    output logic                             pslverr,
    output logic [31:0]                      prdata,
    input  wire logic [scr_pkg::NIRQ-1:0]    ext_irq_pin_n,
    input  wire logic                        ext_reset_pin_n,
    input  wire logic [scr_pkg::MULT_STAT_W-3:0] mult_lock_in,
    output logic [scr_pkg::NIRQ-1:0]         ext_irq_req,
    output logic                             wake_req,
    output logic                             chip_reset_req,
    output logic                             isp_request,
    output scr_pkg::scr_ctrl_t               ctrl,
    output logic                             irq
);
    typedef struct packed {
        logic [1:0][scr_pkg::NIRQ-1:0]   irq_sync;
        logic [1:0]                      rst_sync;
        logic [scr_pkg::NIRQ-1:0]        flags;
        logic [scr_pkg::NIRQ-1:0]        wake_en;
        logic [scr_pkg::NIRQ-1:0]        pin_sel;
        logic [scr_pkg::MAP_W-1:0]       vmap;
        logic [scr_pkg::MULT_CTRL_W-1:0] mult_ctrl;
        logic [scr_pkg::MULT_CTRL_W-1:0] mult_ctrl_act;
        logic [scr_pkg::MULT_CFG_W-1:0]  mult_cfg;
        logic [scr_pkg::MULT_CFG_W-1:0]  mult_cfg_act;
        scr_pkg::scr_feed_t              feed;
        logic [scr_pkg::POWER_MODE_W-1:0] pmode;
        logic [scr_pkg::PPOWER_W-1:0]    pp;
        logic [scr_pkg::PDIV_W-1:0]      pdiv;
        logic [scr_pkg::EVT_W-1:0]       evt_st;
        logic [scr_pkg::EVT_W-1:0]       evt_en;
        logic [1:0]                      boot_wait;
        logic                            boot_done;
        logic                            in_system_programming;
        logic [31:0]                     rdata;
    } scr_state_t;

    scr_state_t state_r;
    scr_state_t state_nxt;

    logic                     wr_acc;
    logic                     rd_acc;
    logic                     hit;
    logic [31:0]              rd_val;
    logic [scr_pkg::NIRQ-1:0] pin_low;
    logic [scr_pkg::NIRQ-1:0] clr_req;
    logic [scr_pkg::EVT_W-1:0] evt_set;
    logic                     wake_any;
    logic                     pdown;

    // single-cycle access: ready in every access phase
    assign wr_acc  = apb_req.psel && apb_req.penable && apb_req.pwrite;
    // read data is caught in the setup cycle so it stands through the access phase
    assign rd_acc  = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign pready  = 1'b1;
    assign pslverr = apb_req.psel && apb_req.penable && !hit;
    assign prdata  = state_r.rdata;

    // second stage only; first sync stage is not looked at
    assign pin_low = ~state_r.irq_sync[1] & state_r.pin_sel; // [R1] [R12] [R16]
    assign pdown   = state_r.pmode[scr_pkg::PMODE_PDOWN];
    assign wake_any = |(state_r.flags & state_r.wake_en & state_r.pin_sel); // [R14]

    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0;
        unique case (apb_req.paddr) // [R5] [R6]
            scr_pkg::ADDR_VECTOR_MAP:   rd_val = {30'h0, state_r.vmap};
            scr_pkg::ADDR_MULT_CTRL:    rd_val = {30'h0, state_r.mult_ctrl};
            scr_pkg::ADDR_MULT_CFG:     rd_val = {25'h0, state_r.mult_cfg};
            scr_pkg::ADDR_MULT_STAT:    rd_val = {21'h0, state_r.mult_ctrl_act,
                                                  mult_lock_in[scr_pkg::MULT_CFG_W-1:0],
                                                  2'h0};
            scr_pkg::ADDR_MULT_FEED:    rd_val = 32'h0;
            scr_pkg::ADDR_POWER_MODE:   rd_val = {30'h0, state_r.pmode};
            scr_pkg::ADDR_PERIPH_POWER: rd_val = {22'h0, state_r.pp};
            scr_pkg::ADDR_PCLK_DIV:     rd_val = {30'h0, state_r.pdiv};
            scr_pkg::ADDR_IRQ_FLAGS:    rd_val = {29'h0, state_r.flags}; // [R17]
            scr_pkg::ADDR_IRQ_WAKE:     rd_val = {29'h0, state_r.wake_en};
            scr_pkg::ADDR_PIN_SELECT:   rd_val = {29'h0, state_r.pin_sel};
            scr_pkg::ADDR_EVT_STATUS:   rd_val = {28'h0, state_r.evt_st};
            scr_pkg::ADDR_EVT_ENABLE:   rd_val = {28'h0, state_r.evt_en};
            scr_pkg::ADDR_EVT_CLEAR:    rd_val = 32'h0;
            scr_pkg::ADDR_BOOT_STATUS:  rd_val = {31'h0, state_r.in_system_programming};
            default: begin
                hit    = 1'b0;
                rd_val = 32'h0;
            end
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        clr_req   = '0;
        evt_set   = '0;
        state_nxt.irq_sync[0] = ext_irq_pin_n; // [R16]
        state_nxt.irq_sync[1] = state_r.irq_sync[0];
        state_nxt.rst_sync[0] = ext_reset_pin_n;
        state_nxt.rst_sync[1] = state_r.rst_sync[0];
        if (rd_acc) begin
            state_nxt.rdata = rd_val;
        end
        // strap waits until both sync stages hold the pin instead of their reset value
        if (!state_r.boot_done) begin
            if (state_r.boot_wait == 2'(scr_pkg::BOOT_SETTLE)) begin
                state_nxt.boot_done = 1'b1;
                state_nxt.in_system_programming       = ~state_r.irq_sync[1][0]; // [R3]
            end else begin
                state_nxt.boot_wait = state_r.boot_wait + 2'h1;
            end
        end
        if (wr_acc) begin
            unique case (apb_req.paddr)
                scr_pkg::ADDR_VECTOR_MAP:
                    state_nxt.vmap = apb_req.pwdata[scr_pkg::MAP_W-1:0]; // [R15]
                scr_pkg::ADDR_MULT_CTRL:
                    state_nxt.mult_ctrl = apb_req.pwdata[scr_pkg::MULT_CTRL_W-1:0];
                scr_pkg::ADDR_MULT_CFG:
                    state_nxt.mult_cfg = apb_req.pwdata[scr_pkg::MULT_CFG_W-1:0];
                scr_pkg::ADDR_MULT_FEED: begin
                    // control and config only take effect after a full feed pair
                    if (state_r.feed == scr_pkg::SCR_FEED_HALF
                        && apb_req.pwdata[7:0] == scr_pkg::FEED_SECOND) begin
                        state_nxt.mult_ctrl_act = state_r.mult_ctrl;
                        state_nxt.mult_cfg_act  = state_r.mult_cfg;
                        state_nxt.feed          = scr_pkg::SCR_FEED_IDLE;
                    end else if (apb_req.pwdata[7:0] == scr_pkg::FEED_FIRST) begin
                        state_nxt.feed = scr_pkg::SCR_FEED_HALF;
                    end else begin
                        state_nxt.feed = scr_pkg::SCR_FEED_IDLE;
                    end
                end
                scr_pkg::ADDR_POWER_MODE:
                    state_nxt.pmode = apb_req.pwdata[scr_pkg::POWER_MODE_W-1:0];
                scr_pkg::ADDR_PERIPH_POWER:
                    state_nxt.pp = apb_req.pwdata[scr_pkg::PPOWER_W-1:0]; // [R9] [R17]
                scr_pkg::ADDR_PCLK_DIV:
                    state_nxt.pdiv = apb_req.pwdata[scr_pkg::PDIV_W-1:0];
                scr_pkg::ADDR_IRQ_FLAGS:
                    clr_req = apb_req.pwdata[scr_pkg::NIRQ-1:0]; // [R7]
                scr_pkg::ADDR_IRQ_WAKE:
                    state_nxt.wake_en = apb_req.pwdata[scr_pkg::NIRQ-1:0]; // [R8]
                scr_pkg::ADDR_PIN_SELECT:
                    state_nxt.pin_sel = apb_req.pwdata[scr_pkg::NIRQ-1:0];
                scr_pkg::ADDR_EVT_ENABLE:
                    state_nxt.evt_en = apb_req.pwdata[scr_pkg::EVT_W-1:0];
                default: begin
                    clr_req = '0;
                end
            endcase
        end
        // a pin still low keeps its flag: the set wins over any clear
        state_nxt.flags = (state_r.flags & ~(clr_req & ~pin_low)) | pin_low; // [R13]
        // any wake source leaves idle or power-down
        if (wake_any && (pdown || state_r.pmode[scr_pkg::PMODE_IDLE])) begin
            state_nxt.pmode = '0; // [R2]
        end
        evt_set = {wake_any && pdown, pin_low & ~state_r.flags};
        state_nxt.evt_st = state_r.evt_st | evt_set;
        if (wr_acc && apb_req.paddr == scr_pkg::ADDR_EVT_CLEAR) begin
            state_nxt.evt_st = (state_r.evt_st
                                & ~apb_req.pwdata[scr_pkg::EVT_W-1:0]) | evt_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin // [R4] [R10]
            state_r               <= '0;
            state_r.irq_sync      <= '1;
            state_r.rst_sync      <= '1;
            state_r.flags         <= scr_pkg::RST_IRQ;
            state_r.wake_en       <= scr_pkg::RST_IRQ;
            state_r.pin_sel       <= scr_pkg::RST_PIN_SELECT;
            state_r.vmap          <= scr_pkg::RST_MAP;
            state_r.pp            <= scr_pkg::RST_PPOWER;
            state_r.feed          <= scr_pkg::SCR_FEED_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign ext_irq_req    = state_r.flags;
    assign wake_req       = wake_any;
    assign chip_reset_req = ~state_r.rst_sync[1]; // [R4]
    assign isp_request    = state_r.in_system_programming;
    assign irq            = |(state_r.evt_st & state_r.evt_en);

    always_comb begin
        ctrl.mult_enable    = state_r.mult_ctrl_act[scr_pkg::MULT_EN_BIT];
        ctrl.mult_connect   = state_r.mult_ctrl_act[scr_pkg::MULT_CON_BIT];
        ctrl.mult_cfg       = state_r.mult_cfg_act;
        ctrl.power_mode     = state_r.pmode;
        ctrl.periph_power   = state_r.pp;
        ctrl.pclk_div       = state_r.pdiv;
        ctrl.vector_map     = state_r.vmap; // [R15]
        ctrl.vector_map_bad = (state_r.vmap == scr_pkg::SCR_MAP_RSVD);
        ctrl.cclk_from_mult = ctrl.mult_enable && ctrl.mult_connect; // [R11]
    end
endmodule : scr_regs
`default_nettype wire

/* File: design/scr_pkg.sv */
// package for the system control register bank: offsets, fields, resets, carriers
// Summary of operation
// R1 - external interrupt pins are active low
// R2 - any external interrupt may wake idle or power-down
// R3 - low first pin after reset requests programming
// R4 - reset pin low resets the whole chip
// R5 - every register sits on a word address
// R6 - unrelated functions never share an address
// R7 - flag register at 0xE01FC140, resets zero
// R8 - wake enable register at 0xE01FC144, resets zero
// R9 - peripheral power enable at 0xE01FC0C4, resets 0x3BE
// R10 - reset values cover implemented bits only
// R11 - processor clock multiplied only when running and connected
// R12 - interrupt input acts only when pin function selected
// R13 - flag sets while pin low, clears after high
// R14 - wake enable wakes power down without controller enable
// R15 - vector map: boot, flash, static ram, reserved
// R16 - two-stage synchroniser on every pin
// R17 - reserved bits read zero, writes ignored
package scr_pkg;
    localparam logic [31:0] ADDR_VECTOR_MAP   = 32'hE01FC040;
    localparam logic [31:0] ADDR_MULT_CTRL    = 32'hE01FC080;
    localparam logic [31:0] ADDR_MULT_CFG     = 32'hE01FC084;
    localparam logic [31:0] ADDR_MULT_STAT    = 32'hE01FC088;
    localparam logic [31:0] ADDR_MULT_FEED    = 32'hE01FC08C;
    localparam logic [31:0] ADDR_POWER_MODE   = 32'hE01FC0C0;
    localparam logic [31:0] ADDR_PERIPH_POWER = 32'hE01FC0C4;
    localparam logic [31:0] ADDR_PCLK_DIV     = 32'hE01FC100;
    localparam logic [31:0] ADDR_IRQ_FLAGS    = 32'hE01FC140;
    localparam logic [31:0] ADDR_IRQ_WAKE     = 32'hE01FC144;
    // pin function select, event and boot status registers, placed in a spare part of the space
    localparam logic [31:0] ADDR_PIN_SELECT   = 32'hE01FC180;
    localparam logic [31:0] ADDR_EVT_STATUS   = 32'hE01FC184;
    localparam logic [31:0] ADDR_EVT_ENABLE   = 32'hE01FC188;
    localparam logic [31:0] ADDR_EVT_CLEAR    = 32'hE01FC18C;
    localparam logic [31:0] ADDR_BOOT_STATUS  = 32'hE01FC190;

    localparam int          MAP_W        = 2;
    localparam int          MULT_CTRL_W  = 2;
    localparam int          MULT_CFG_W   = 7;
    localparam int          MULT_STAT_W  = 11;
    localparam int          POWER_MODE_W = 2;
    localparam int          PPOWER_W     = 10;
    localparam int          PDIV_W       = 2;
    localparam int          NIRQ         = 3;
    localparam int          EVT_W        = 4;
    localparam int          MULT_EN_BIT  = 0;
    localparam int          MULT_CON_BIT = 1;
    localparam int          PMODE_IDLE   = 0;
    localparam int          PMODE_PDOWN  = 1;
    localparam int          EVT_WAKE_BIT = 3;
    localparam logic [7:0]  FEED_FIRST   = 8'hAA;
    localparam logic [7:0]  FEED_SECOND  = 8'h55;
    localparam int          BOOT_SETTLE  = 2;

    localparam logic [MAP_W-1:0]        RST_MAP        = 2'h0;
    localparam logic [PPOWER_W-1:0]     RST_PPOWER     = 10'h3BE;
    localparam logic [NIRQ-1:0]         RST_IRQ        = 3'h0;
    localparam logic [NIRQ-1:0]         RST_PIN_SELECT = 3'h0;

    typedef enum logic [1:0] {
        SCR_MAP_BOOT  = 2'h0,
        SCR_MAP_FLASH = 2'h1,
        SCR_MAP_SRAM  = 2'h2,
        SCR_MAP_RSVD  = 2'h3
    } scr_map_t;

    typedef enum {SCR_FEED_IDLE, SCR_FEED_HALF} scr_feed_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } scr_apb_req_t;

    typedef struct packed {
        logic                    mult_enable;
        logic                    mult_connect;
        logic [MULT_CFG_W-1:0]   mult_cfg;
        logic [POWER_MODE_W-1:0] power_mode;
        logic [PPOWER_W-1:0]     periph_power;
        logic [PDIV_W-1:0]       pclk_div;
        logic [MAP_W-1:0]        vector_map;
        logic                    vector_map_bad;
        logic                    cclk_from_mult;
    } scr_ctrl_t;
endpackage : scr_pkg

/* File: verification/scr_regs_sva.sv */
// port assertions for the system control register bank
`timescale 1ns/1ps
`default_nettype none
module scr_regs_sva (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire scr_pkg::scr_apb_req_t    apb_req,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire logic [scr_pkg::NIRQ-1:0] ext_irq_pin_n,
    input wire logic                     ext_reset_pin_n,
    input wire logic [scr_pkg::NIRQ-1:0] ext_irq_req,
    input wire logic                     wake_req,
    input wire scr_pkg::scr_ctrl_t       ctrl
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = apb_req.psel && apb_req.penable;
    wire logic wr  = acc && apb_req.pwrite;
    wire logic hit = apb_req.paddr inside {scr_pkg::ADDR_VECTOR_MAP, scr_pkg::ADDR_MULT_CTRL,
        scr_pkg::ADDR_MULT_CFG, scr_pkg::ADDR_MULT_STAT, scr_pkg::ADDR_MULT_FEED,
        scr_pkg::ADDR_POWER_MODE, scr_pkg::ADDR_PERIPH_POWER, scr_pkg::ADDR_PCLK_DIV,
        scr_pkg::ADDR_IRQ_FLAGS, scr_pkg::ADDR_IRQ_WAKE, scr_pkg::ADDR_PIN_SELECT,
        scr_pkg::ADDR_EVT_STATUS, scr_pkg::ADDR_EVT_ENABLE, scr_pkg::ADDR_EVT_CLEAR,
        scr_pkg::ADDR_BOOT_STATUS};
    AST_BAD_ADDR: assert property (acc && !hit |-> pslverr)
        else $error("unmapped access without slave error");
    AST_GOOD_ADDR: assert property (acc && hit |-> pready && !pslverr)
        else $error("mapped access refused");
    // the sync adds two or three edges, so a new flag needs the pin low in that span
    AST_FLAG_SET: assert property (!(|(ext_irq_req & ~$past(ext_irq_req)
        & $past(ext_irq_pin_n, 2) & $past(ext_irq_pin_n, 3)))) else $error("flag set by high pin");
    AST_FLAG_KEEP: assert property (!(|(~ext_irq_req & $past(ext_irq_req)
        & ~$past(ext_irq_pin_n, 2) & ~$past(ext_irq_pin_n, 3)))) else $error("flag lost, pin low");
    AST_FLAG_CLR: assert property (|(~ext_irq_req & $past(ext_irq_req))
        |-> $past(wr && apb_req.paddr == scr_pkg::ADDR_IRQ_FLAGS)) else $error("flag fell alone");
    AST_WAKE: assert property (wake_req |-> |ext_irq_req)
        else $error("wake without flag");
    AST_CCLK: assert property (ctrl.cclk_from_mult == (ctrl.mult_enable && ctrl.mult_connect))
        else $error("clock source select wrong");
    AST_MAP_BAD: assert property (ctrl.vector_map_bad == (ctrl.vector_map == 2'h3))
        else $error("reserved map flag wrong");
    AST_PPOWER: assert property ($changed(ctrl.periph_power)
        |-> $past(wr && apb_req.paddr == scr_pkg::ADDR_PERIPH_POWER)) else $error("power moved");
endmodule : scr_regs_sva
bind scr_regs scr_regs_sva scr_regs_sva_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .pready(pready), .pslverr(pslverr), .ext_irq_pin_n(ext_irq_pin_n),
    .ext_reset_pin_n(ext_reset_pin_n), .ext_irq_req(ext_irq_req), .wake_req(wake_req),
    .ctrl(ctrl));
`default_nettype wire

/* File: verification/scr_pins_model.sv */
// model of the external interrupt sources and the reset pin driver
`timescale 1ns/1ps
`default_nettype none
module scr_pins_model (
    input  wire logic       pclk,
    input  wire logic [2:0] want_irq_n,
    input  wire logic       want_rst_n,
    output logic [2:0]      ext_irq_pin_n,
    output logic            ext_reset_pin_n
);
    // sources idle high and pull low to request, so a silent source never asks
    initial ext_irq_pin_n = 3'h7;
    initial ext_reset_pin_n = 1'b1;
    always @(posedge pclk) begin
        ext_irq_pin_n   <= want_irq_n;
        ext_reset_pin_n <= want_rst_n;
    end
endmodule : scr_pins_model
`default_nettype wire

/* File: verification/tb_system_control_regs_ext_irq.sv */
// self-checking bench for the system control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_system_control_regs_ext_irq;
    logic                  pclk = 1'b0, presetn = 1'b0, want_rst_n = 1'b1;
    scr_pkg::scr_apb_req_t req = '0;
    logic                  pready, pslverr, wake_req, chip_reset_req, isp_request, irq, e, rst_n;
    logic [31:0]           prdata, q;
    logic [2:0]            pins_n, flags, want_n = 3'h7;
    logic [8:0]            lock = 9'h000;
    scr_pkg::scr_ctrl_t    ctrl;
    int                    fail_count = 0, check_count = 0, cycles = 0;
    logic [31:0]           ra [9] = '{scr_pkg::ADDR_VECTOR_MAP, scr_pkg::ADDR_MULT_CTRL,
        scr_pkg::ADDR_MULT_CFG, scr_pkg::ADDR_PCLK_DIV, scr_pkg::ADDR_IRQ_WAKE,
        scr_pkg::ADDR_PERIPH_POWER, scr_pkg::ADDR_MULT_STAT, scr_pkg::ADDR_POWER_MODE,
        scr_pkg::ADDR_IRQ_FLAGS};
    // ones go only to the first six; power mode would sleep and flags would clear
    logic [31:0]           wm [6] = '{32'h3, 32'h3, 32'h7F, 32'h3, 32'h7, 32'h3FF};

    scr_regs scr_regs_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .ext_irq_pin_n(pins_n), .ext_reset_pin_n(rst_n),
        .mult_lock_in(lock), .ext_irq_req(flags), .wake_req(wake_req),
        .chip_reset_req(chip_reset_req), .isp_request(isp_request), .ctrl(ctrl), .irq(irq));
    scr_pins_model scr_pins_model_inst (.pclk(pclk), .want_irq_n(want_n),
        .want_rst_n(want_rst_n), .ext_irq_pin_n(pins_n), .ext_reset_pin_n(rst_n));

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // the answer, read data included, is taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        e = pslverr;
        q = prdata;
        req <= '0;
        #1;
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rd
    task automatic drive(input logic [2:0] irq_n, input logic rst_pin_n);
        @(posedge pclk);
        want_n <= irq_n;
        want_rst_n <= rst_pin_n;
        repeat (6) @(posedge pclk);
        #1;
    endtask : drive

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) rd(ra[i], (i == 5) ? 32'h3BE : 32'h0);
        rd(scr_pkg::ADDR_BOOT_STATUS, 32'h0);
        foreach (wm[i]) begin
            wr(ra[i], 32'hFFFFFFFF);
            rd(ra[i], wm[i]);
        end
        for (int m = 0; m < 4; m++) begin
            wr(scr_pkg::ADDR_VECTOR_MAP, 32'(m));
            rd(scr_pkg::ADDR_VECTOR_MAP, 32'(m));
            check(32'(ctrl.vector_map_bad), 32'(m == 3));
        end
        apb(1'b1, 32'hE01FC044, 32'hFFFFFFFF);
        check(32'(e), 32'h1);
        apb(1'b0, 32'hE01FC044, 32'h0);
        check({q[30:0], e}, 32'h1);
        wr(scr_pkg::ADDR_PIN_SELECT, 32'h3);
        drive(3'h0, 1'b1);
        check(32'(flags), 32'h3);
        wr(scr_pkg::ADDR_IRQ_FLAGS, 32'h7);
        rd(scr_pkg::ADDR_IRQ_FLAGS, 32'h3);
        rd(scr_pkg::ADDR_EVT_STATUS, 32'h3);
        check(32'(irq), 32'h0);
        wr(scr_pkg::ADDR_EVT_ENABLE, 32'h1);
        check(32'(irq), 32'h1);
        drive(3'h7, 1'b1);
        wr(scr_pkg::ADDR_IRQ_FLAGS, 32'h7);
        rd(scr_pkg::ADDR_IRQ_FLAGS, 32'h0);
        wr(scr_pkg::ADDR_EVT_CLEAR, 32'hF);
        check(32'(irq), 32'h0);
        wr(scr_pkg::ADDR_IRQ_WAKE, 32'h4);
        wr(scr_pkg::ADDR_PIN_SELECT, 32'h7);
        wr(scr_pkg::ADDR_POWER_MODE, 32'h2);
        drive(3'h3, 1'b1);
        check(32'(wake_req), 32'h1);
        rd(scr_pkg::ADDR_POWER_MODE, 32'h0);
        rd(scr_pkg::ADDR_EVT_STATUS, 32'hC);
        drive(3'h7, 1'b1);
        wr(scr_pkg::ADDR_IRQ_FLAGS, 32'h7);
        @(posedge pclk);
        lock <= 9'h055;
        wr(scr_pkg::ADDR_MULT_CTRL, 32'h3);
        wr(scr_pkg::ADDR_MULT_FEED, {24'h0, scr_pkg::FEED_FIRST});
        wr(scr_pkg::ADDR_MULT_FEED, 32'h12);
        check(32'(ctrl.cclk_from_mult), 32'h0);
        wr(scr_pkg::ADDR_MULT_FEED, {24'h0, scr_pkg::FEED_FIRST});
        wr(scr_pkg::ADDR_MULT_FEED, {24'h0, scr_pkg::FEED_SECOND});
        check(32'(ctrl.cclk_from_mult), 32'h1);
        rd(scr_pkg::ADDR_MULT_STAT, 32'h754);
        drive(3'h7, 1'b0);
        check(32'(chip_reset_req), 32'h1);
        drive(3'h6, 1'b1);
        check(32'(chip_reset_req), 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        #1 check(32'(isp_request), 32'h1);
        rd(scr_pkg::ADDR_BOOT_STATUS, 32'h1);
        rd(scr_pkg::ADDR_PERIPH_POWER, 32'h3BE);
        wrap_up();
    end
endmodule : tb_system_control_regs_ext_irq
`default_nettype wire
